/* src/acex_top.sv */
// Asynchronous serial element with baud generator and host port.
`timescale 1ns/1ps
`include "acex_defs.svh"
module acex_top (
   // Clock and resets
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       master_reset,
   // Host bus
   input  wire logic       select_latch_strobe_n,
   input  wire logic [2:0] reg_sel,
   input  wire logic [2:0] chip_select_inputs,
   input  wire logic       host_read_strobe_n,
   input  wire logic       host_write_strobe_n,
   input  wire logic [7:0] host_wdata,
   output logic      [7:0] host_rdata,
   output logic            rdata_valid_n,
   output logic            selected_indicator,
   output logic            xcvr_disable,
   output logic            irq_out,
   // Clocks as sampled levels
   input  wire logic       baud_ref_clock,
   output logic            baud_tick_out_n,
   input  wire logic       rx_clock16,
   // Serial line
   output logic            serial_tx,
   input  wire logic       serial_rx,
   // Modem
   input  wire logic       clear_to_send_n,
   input  wire logic       set_ready_n,
   input  wire logic       ring_detect_n,
   input  wire logic       carrier_detect_n,
   output logic            terminal_ready_n,
   output logic            request_to_send_n,
   output logic      [1:0] user_outputs_n
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic                 rst;
   logic [2:0]           sel_ff;
   logic [2:0]           cs_ff;
   logic                 chip_on;
   logic                 rd_on;
   logic                 wr_on;
   logic                 rd_prev_ff;
   logic                 wr_prev_ff;
   logic                 rd_go;
   logic                 wr_go;
   logic                 dlab;
   logic                 loop;
   logic                 wr_thr;
   logic                 rd_rbr;
   logic [3:0]           ier_ff;
   logic [7:0]           lcr_ff;
   logic [4:0]           mcr_ff;
   logic [15:0]          div_ff;
   logic [7:0]           scr_ff;
   logic                 ref_q_ff;
   logic                 ref_tick;
   logic [15:0]          brg_ff;
   logic                 tick16;
   logic                 tick_out_ff;
   logic [2:0]           last_bit;
   logic [7:0]           mask;
   logic [5:0]           stop_len;
   logic                 nxt_par;
   logic [7:0]           thr_ff;
   logic                 thr_full_ff;
   logic [7:0]           tsr_ff;
   acex_pkg::acex_fsm_type tx_st_ff;
   logic [5:0]           tx_sub_ff;
   logic [2:0]           tx_cnt_ff;
   logic                 tx_par_ff;
   logic                 tx_line_ff;
   logic                 tx_int;
   logic                 tx_bit_end;
   logic                 tx_load;
   logic                 tx_ff;
   logic                 rxc_q_ff;
   logic                 rx16;
   logic                 rx_in;
   acex_pkg::acex_fsm_type rx_st_ff;
   logic [3:0]           rx_sub_ff;
   logic [2:0]           rx_cnt_ff;
   logic [7:0]           rx_sr_ff;
   logic                 rx_x_ff;
   logic                 rx_pe_ff;
   logic                 rx_zero_ff;
   logic                 rx_smp;
   logic                 rx_done;
   logic [7:0]           rbr_ff;
   logic                 dr_ff;
   logic                 oe_ff;
   logic                 pe_ff;
   logic                 fe_ff;
   logic                 bi_ff;
   logic                 thre;
   logic                 temt;
   logic                 thre_pend_ff;
   logic [3:0]           ms_now;
   logic [3:0]           ms_q_ff;
   logic [3:0]           delta_ff;
   logic [3:0]           iid;
   logic [7:0]           rdata_ff;
   logic                 irq_ff;

   // Both resets clear every flip-flop to a constant.
   assign rst = reset | master_reset;

   // ****************************************************************
   // Host port
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_ff <= `ACEX_A_DATA;
         cs_ff  <= 3'h4;
      end else if (!select_latch_strobe_n) begin
         sel_ff <= reg_sel;
         cs_ff  <= chip_select_inputs;
      end
   end

   assign chip_on = cs_ff[0] & cs_ff[1] & ~cs_ff[2];
   assign rd_on   = chip_on & ~host_read_strobe_n;
   assign wr_on   = chip_on & ~host_write_strobe_n;
   assign rd_go   = rd_on & ~rd_prev_ff;
   assign wr_go   = wr_on & ~wr_prev_ff;

   // Side effects act once per strobe, on its first selected cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rd_prev_ff <= 1'b0;
         wr_prev_ff <= 1'b0;
      end else begin
         rd_prev_ff <= rd_on;
         wr_prev_ff <= wr_on;
      end
   end

   assign selected_indicator = chip_on;
   assign xcvr_disable       = rd_on;
   assign rdata_valid_n      = ~(rd_on & rd_prev_ff);
   assign host_rdata         = rdata_ff;
   assign irq_out            = irq_ff;

   assign dlab   = lcr_ff[`ACEX_LC_DLAB];
   assign loop   = mcr_ff[`ACEX_MC_LOOP];
   assign wr_thr = wr_go & (sel_ff == `ACEX_A_DATA) & ~dlab;
   assign rd_rbr = rd_go & (sel_ff == `ACEX_A_DATA) & ~dlab;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ier_ff <= 4'h0;
         lcr_ff <= `ACEX_RST_BYTE;
         mcr_ff <= 5'h00;
         div_ff <= `ACEX_RST_DIV;
         scr_ff <= `ACEX_RST_BYTE;
      end else if (wr_go) begin
         case (sel_ff)
            `ACEX_A_DATA: begin
               if (dlab) div_ff[7:0] <= host_wdata;
            end
            `ACEX_A_IEN: begin
               if (dlab) div_ff[15:8] <= host_wdata;
               else ier_ff <= host_wdata[3:0];
            end
            `ACEX_A_LCTL: lcr_ff <= host_wdata;
            `ACEX_A_MCTL: mcr_ff <= host_wdata[4:0];
            `ACEX_A_SCR: scr_ff <= host_wdata;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Baud generator
   // ****************************************************************
   assign ref_tick = baud_ref_clock & ~ref_q_ff;
   // A zero divisor stops the generator rather than dividing by zero.
   assign tick16 = ref_tick & (div_ff != `ACEX_RST_DIV)
                   & (brg_ff <= 16'h0001);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ref_q_ff    <= 1'b0;
         brg_ff      <= `ACEX_RST_DIV;
         tick_out_ff <= 1'b0;
      end else begin
         ref_q_ff    <= baud_ref_clock;
         tick_out_ff <= tick16;
         if (wr_go & dlab & (sel_ff <= `ACEX_A_IEN))
            brg_ff <= `ACEX_RST_DIV;
         else if (tick16)
            brg_ff <= div_ff;
         else if (ref_tick)
            brg_ff <= brg_ff - 16'h0001;
      end
   end

   assign baud_tick_out_n = ~tick_out_ff;

   // ****************************************************************
   // Frame format
   // ****************************************************************
   assign last_bit = `ACEX_LAST_MIN + {1'b0, lcr_ff[1:0]};
   assign mask     = `ACEX_ONES >> (`ACEX_WLS_MAX - lcr_ff[1:0]);
   always_comb begin
      if (!lcr_ff[`ACEX_LC_STB])
         stop_len = `ACEX_T_BIT;
      else if (lcr_ff[1:0] == 2'h0)
         stop_len = `ACEX_T_1P5;
      else
         stop_len = `ACEX_T_2;
   end
   always_comb begin
      if (lcr_ff[`ACEX_LC_STICK])
         nxt_par = ~lcr_ff[`ACEX_LC_EPS];
      else
         nxt_par = (^(thr_ff & mask)) ^ ~lcr_ff[`ACEX_LC_EPS];
   end

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   assign tx_bit_end = (tx_st_ff == acex_pkg::st_stop)
                       ? (tx_sub_ff == stop_len - 6'h01)
                       : (tx_sub_ff == `ACEX_T_BIT - 6'h01);
   // Holding register refills the shifter back to back.
   assign tx_load = tick16 & thr_full_ff &
                    ((tx_st_ff == acex_pkg::st_idle) |
                     ((tx_st_ff == acex_pkg::st_stop) & tx_bit_end));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         thr_ff      <= `ACEX_RST_BYTE;
         thr_full_ff <= 1'b0;
      end else begin
         if (wr_thr) thr_ff <= host_wdata;
         if (wr_thr) thr_full_ff <= 1'b1;
         else if (tx_load) thr_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_st_ff   <= acex_pkg::st_idle;
         tsr_ff     <= `ACEX_RST_BYTE;
         tx_sub_ff  <= 6'h00;
         tx_cnt_ff  <= 3'h0;
         tx_par_ff  <= 1'b0;
         tx_line_ff <= 1'b1;
      end else if (tx_load) begin
         tx_st_ff   <= acex_pkg::st_start;
         tsr_ff     <= thr_ff;
         tx_par_ff  <= nxt_par;
         tx_sub_ff  <= 6'h00;
         tx_line_ff <= 1'b0;
      end else if (tick16) begin
         tx_sub_ff <= tx_bit_end ? 6'h00 : tx_sub_ff + 6'h01;
         case (tx_st_ff)
            acex_pkg::st_start: if (tx_bit_end) begin
               tx_st_ff   <= acex_pkg::st_data;
               tx_cnt_ff  <= 3'h0;
               tx_line_ff <= tsr_ff[0];
            end
            acex_pkg::st_data: if (tx_bit_end) begin
               if (tx_cnt_ff == last_bit) begin
                  if (lcr_ff[`ACEX_LC_PEN]) begin
                     tx_st_ff   <= acex_pkg::st_par;
                     tx_line_ff <= tx_par_ff;
                  end else begin
                     tx_st_ff   <= acex_pkg::st_stop;
                     tx_line_ff <= 1'b1;
                  end
               end else begin
                  tsr_ff     <= tsr_ff >> 1;
                  tx_line_ff <= tsr_ff[1];
                  tx_cnt_ff  <= tx_cnt_ff + 3'h1;
               end
            end
            acex_pkg::st_par: if (tx_bit_end) begin
               tx_st_ff   <= acex_pkg::st_stop;
               tx_line_ff <= 1'b1;
            end
            acex_pkg::st_stop: if (tx_bit_end) begin
               tx_st_ff <= acex_pkg::st_idle;
            end
            default: tx_st_ff <= acex_pkg::st_idle;
         endcase
      end
   end

   assign tx_int = tx_line_ff & ~lcr_ff[`ACEX_LC_BRK];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) tx_ff <= 1'b1;
      else tx_ff <= loop | tx_int;
   end
   assign serial_tx = tx_ff;

   assign thre = ~thr_full_ff;
   assign temt = thre & (tx_st_ff == acex_pkg::st_idle);

   // ****************************************************************
   // Receiver
   // ****************************************************************
   assign rx16    = rx_clock16 & ~rxc_q_ff;
   assign rx_in   = loop ? tx_int : serial_rx;
   assign rx_smp  = rx16 & (rx_sub_ff == `ACEX_T_END);
   assign rx_done = rx_smp & (rx_st_ff == acex_pkg::st_stop);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rxc_q_ff   <= 1'b0;
         rx_st_ff   <= acex_pkg::st_idle;
         rx_sub_ff  <= 4'h0;
         rx_cnt_ff  <= 3'h0;
         rx_sr_ff   <= `ACEX_RST_BYTE;
         rx_x_ff    <= 1'b0;
         rx_pe_ff   <= 1'b0;
         rx_zero_ff <= 1'b1;
      end else begin
         rxc_q_ff <= rx_clock16;
         if (rx16) begin
            rx_sub_ff <= rx_sub_ff + 4'h1;
            case (rx_st_ff)
               acex_pkg::st_idle: begin
                  rx_sub_ff <= 4'h0;
                  if (!rx_in) rx_st_ff <= acex_pkg::st_start;
               end
               acex_pkg::st_start: if (rx_sub_ff == `ACEX_T_MID) begin
                  // Start rechecked mid-bit to reject short glitches.
                  rx_sub_ff  <= 4'h0;
                  rx_cnt_ff  <= 3'h0;
                  rx_x_ff    <= 1'b0;
                  rx_zero_ff <= 1'b1;
                  // Cleared per frame so a frame without parity never
                  // reports an error left over from an earlier frame.
                  rx_pe_ff   <= 1'b0;
                  rx_st_ff   <= rx_in ? acex_pkg::st_idle
                                      : acex_pkg::st_data;
               end
               acex_pkg::st_data: if (rx_smp) begin
                  rx_sr_ff   <= {rx_in, rx_sr_ff[7:1]};
                  rx_x_ff    <= rx_x_ff ^ rx_in;
                  rx_zero_ff <= rx_zero_ff & ~rx_in;
                  rx_cnt_ff  <= rx_cnt_ff + 3'h1;
                  if (rx_cnt_ff == last_bit)
                     rx_st_ff <= lcr_ff[`ACEX_LC_PEN]
                                 ? acex_pkg::st_par
                                 : acex_pkg::st_stop;
               end
               acex_pkg::st_par: if (rx_smp) begin
                  rx_zero_ff <= rx_zero_ff & ~rx_in;
                  rx_pe_ff   <= rx_in ^ (lcr_ff[`ACEX_LC_STICK]
                                 ? ~lcr_ff[`ACEX_LC_EPS]
                                 : rx_x_ff ^ ~lcr_ff[`ACEX_LC_EPS]);
                  rx_st_ff   <= acex_pkg::st_stop;
               end
               acex_pkg::st_stop: if (rx_smp) begin
                  // A held low line must return to mark first.
                  rx_st_ff <= rx_in ? acex_pkg::st_idle
                                    : acex_pkg::st_wait;
               end
               acex_pkg::st_wait: if (rx_in) begin
                  rx_st_ff <= acex_pkg::st_idle;
               end
               default: rx_st_ff <= acex_pkg::st_idle;
            endcase
         end
      end
   end

   // ****************************************************************
   // Line status; hardware set wins over a host clear
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rbr_ff <= `ACEX_RST_BYTE;
         dr_ff  <= 1'b0;
      end else begin
         if (rx_done)
            rbr_ff <= (rx_sr_ff >> (`ACEX_WLS_MAX - lcr_ff[1:0]));
         if (rx_done) dr_ff <= 1'b1;
         else if (rd_rbr) dr_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         oe_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
         bi_ff <= 1'b0;
      end else begin
         if (rd_go & (sel_ff == `ACEX_A_LSTAT)) begin
            oe_ff <= 1'b0;
            pe_ff <= 1'b0;
            fe_ff <= 1'b0;
            bi_ff <= 1'b0;
         end
         if (rx_done) begin
            if (dr_ff & ~rd_rbr) oe_ff <= 1'b1;
            if (rx_pe_ff) pe_ff <= 1'b1;
            if (!rx_in) fe_ff <= 1'b1;
            if (!rx_in & rx_zero_ff) bi_ff <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Modem status
   // ****************************************************************
   // In loop the modem outputs feed the status bits directly.
   assign ms_now = loop ? {mcr_ff[`ACEX_MC_OUT2], mcr_ff[`ACEX_MC_OUT1],
                           mcr_ff[`ACEX_MC_DTR], mcr_ff[`ACEX_MC_RTS]}
                        : ~{carrier_detect_n, ring_detect_n,
                            set_ready_n, clear_to_send_n};

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) ms_q_ff <= 4'h0;
      else ms_q_ff <= ms_now;
   end

   for (genvar i = 0; i < 4; i++) begin : g_delta
      // Ring reports only its trailing edge.
      logic ev;
      assign ev = (i == 2) ? (ms_q_ff[i] & ~ms_now[i])
                           : (ms_q_ff[i] ^ ms_now[i]);
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) delta_ff[i] <= 1'b0;
         else if (ev) delta_ff[i] <= 1'b1;
         else if (rd_go & (sel_ff == `ACEX_A_MSTAT))
            delta_ff[i] <= 1'b0;
      end
   end

   assign terminal_ready_n  = ~(mcr_ff[`ACEX_MC_DTR] & ~loop);
   assign request_to_send_n = ~(mcr_ff[`ACEX_MC_RTS] & ~loop);
   assign user_outputs_n    = ~(mcr_ff[`ACEX_MC_OUT2:`ACEX_MC_OUT1]
                                & {2{~loop}});

   // ****************************************************************
   // Interrupt priority
   // ****************************************************************
   always_comb begin
      if (ier_ff[`ACEX_IE_LS] & (oe_ff | pe_ff | fe_ff | bi_ff))
         iid = `ACEX_ID_LS;
      else if (ier_ff[`ACEX_IE_RX] & dr_ff)
         iid = `ACEX_ID_RX;
      else if (ier_ff[`ACEX_IE_TX] & thre_pend_ff)
         iid = `ACEX_ID_TX;
      else if (ier_ff[`ACEX_IE_MS] & (|delta_ff))
         iid = `ACEX_ID_MS;
      else
         iid = `ACEX_ID_NONE;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         thre_pend_ff <= 1'b0;
         irq_ff       <= 1'b0;
      end else begin
         irq_ff <= (iid != `ACEX_ID_NONE);
         if (tx_load & ~wr_thr) thre_pend_ff <= 1'b1;
         else if (wr_thr | (rd_go & (sel_ff == `ACEX_A_IID)
                           & (iid == `ACEX_ID_TX)))
            thre_pend_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) rdata_ff <= `ACEX_RST_BYTE;
      else if (rd_go) begin
         case (sel_ff)
            `ACEX_A_DATA: rdata_ff <= dlab ? div_ff[7:0] : rbr_ff;
            `ACEX_A_IEN: rdata_ff <= dlab ? div_ff[15:8]
                                          : {4'h0, ier_ff};
            `ACEX_A_IID: rdata_ff <= {4'h0, iid};
            `ACEX_A_LCTL: rdata_ff <= lcr_ff;
            `ACEX_A_MCTL: rdata_ff <= {3'h0, mcr_ff};
            `ACEX_A_LSTAT: rdata_ff <= {1'b0, temt, thre, bi_ff,
                                         fe_ff, pe_ff, oe_ff, dr_ff};
            `ACEX_A_MSTAT: rdata_ff <= {ms_now, delta_ff};
            default: rdata_ff <= scr_ff;
         endcase
      end
   end

endmodule // acex_top

/* src/acex_defs.svh */
// Register indices, field positions, codes and timing constants for acex.
`ifndef ACEX_DEFS_SVH
`define ACEX_DEFS_SVH
// ****************************************************************
// Register indices on the three-bit register select
// ****************************************************************
`define ACEX_A_DATA   3'h0
`define ACEX_A_IEN    3'h1
`define ACEX_A_IID    3'h2
`define ACEX_A_LCTL   3'h3
`define ACEX_A_MCTL   3'h4
`define ACEX_A_LSTAT  3'h5
`define ACEX_A_MSTAT  3'h6
`define ACEX_A_SCR    3'h7
// ****************************************************************
// Field positions
// ****************************************************************
`define ACEX_LC_STB   2
`define ACEX_LC_PEN   3
`define ACEX_LC_EPS   4
`define ACEX_LC_STICK 5
`define ACEX_LC_BRK   6
`define ACEX_LC_DLAB  7
`define ACEX_MC_DTR   0
`define ACEX_MC_RTS   1
`define ACEX_MC_OUT1  2
`define ACEX_MC_OUT2  3
`define ACEX_MC_LOOP  4
`define ACEX_IE_RX    0
`define ACEX_IE_TX    1
`define ACEX_IE_LS    2
`define ACEX_IE_MS    3
// ****************************************************************
// Reset values, codes and timing
// ****************************************************************
`define ACEX_RST_BYTE 8'h00
`define ACEX_RST_DIV  16'h0000
`define ACEX_ONES     8'hFF
`define ACEX_LAST_MIN 3'h4
`define ACEX_WLS_MAX  2'h3
`define ACEX_ID_NONE  4'h1
`define ACEX_ID_LS    4'h6
`define ACEX_ID_RX    4'h4
`define ACEX_ID_TX    4'h2
`define ACEX_ID_MS    4'h0
`define ACEX_T_BIT    6'h10
`define ACEX_T_1P5    6'h18
`define ACEX_T_2      6'h20
`define ACEX_T_MID    4'h7
`define ACEX_T_END    4'hF
`endif

/* src/acex_pkg.sv */
// Shared types of the acex serial element.
package acex_pkg;
   typedef enum logic [2:0] {
      st_idle, st_start, st_data, st_par, st_stop, st_wait
   } acex_fsm_type;
endpackage

/* dv/acex_checker.sv */
// Concurrent checks on the host port and baud tick of acex_top.
`timescale 1ns/1ps
module acex_checker (
   // Clock and resets
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       master_reset,
   // Host port and baud tick
   input wire logic       select_latch_strobe_n,
   input wire logic [2:0] chip_select_inputs,
   input wire logic       host_read_strobe_n,
   input wire logic [7:0] host_rdata,
   input wire logic       rdata_valid_n,
   input wire logic       selected_indicator,
   input wire logic       xcvr_disable,
   input wire logic       baud_tick_out_n
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset || master_reset);
   AST_SEL_ON: assert property ($rose(selected_indicator) |->
      $past(!select_latch_strobe_n && chip_select_inputs == 3'b011))
      else $error("select rose without a latched select");
   AST_SEL_OFF: assert property ($fell(selected_indicator) |->
      $past(!select_latch_strobe_n)) else $error("select lost unlatched");
   AST_XCVR_DISABLE: assert property (xcvr_disable ==
      (selected_indicator && !host_read_strobe_n))
      else $error("transceiver disable wrong");
   AST_VALID: assert property (!rdata_valid_n |->
      (!host_read_strobe_n && selected_indicator))
      else $error("valid outside a read");
   AST_RD_ANS: assert property (selected_indicator &&
      $fell(host_read_strobe_n) |=> rdata_valid_n == host_read_strobe_n)
      else $error("read data not valid one cycle after strobe");
   AST_RD_HOLD: assert property (!rdata_valid_n &&
      $past(!rdata_valid_n) |-> $stable(host_rdata))
      else $error("read data moved while valid");
   AST_RD_END: assert property ($rose(host_read_strobe_n) |->
      rdata_valid_n) else $error("valid stayed after strobe");
   AST_BAUD: assert property (!baud_tick_out_n |=> baud_tick_out_n)
      else $error("baud tick longer than one cycle");
   cover property (!rdata_valid_n);
   cover property ($rose(selected_indicator));
   cover property (!baud_tick_out_n);
endmodule // acex_checker
bind acex_top acex_checker i_chk (.clk_sys(clk_sys), .reset(reset),
   .master_reset(master_reset), .select_latch_strobe_n(select_latch_strobe_n),
   .chip_select_inputs(chip_select_inputs),
   .host_read_strobe_n(host_read_strobe_n), .host_rdata(host_rdata),
   .rdata_valid_n(rdata_valid_n), .selected_indicator(selected_indicator),
   .xcvr_disable(xcvr_disable), .baud_tick_out_n(baud_tick_out_n));

/* dv/acex_modem.sv */
// Modem and receive clock source on the far side of the serial element.
`timescale 1ns/1ps
module acex_modem (
   // Serial side
   input  wire logic serial_tx,
   input  wire logic echo_on,
   input  wire logic baud_tick_out_n,
   output logic      serial_rx,
   output logic      rx_clock16,
   // Modem status
   output logic      clear_to_send_n,
   output logic      set_ready_n,
   output logic      ring_detect_n,
   output logic      carrier_detect_n
);
   assign rx_clock16 = ~baud_tick_out_n;
   // With echo off the line sits at spacing, which a looped receiver
   // must never see.
   assign serial_rx = echo_on ? serial_tx : 1'b0;
   assign clear_to_send_n = 1'b0;
   assign set_ready_n = 1'b0;
   assign ring_detect_n = 1'b1;
   assign carrier_detect_n = 1'b0;
endmodule // acex_modem

/* dv/testbench.sv */
// Self-checking bench for acex_top.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
   err_total++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module testbench;
   logic clk_sys = 1'b0, reset = 1'b1, master_reset = 1'b0, ref_clk = 1'b0;
   logic latch_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, echo_on = 1'b1, lp;
   logic [2:0] reg_sel = 3'h0, cs_in = 3'h4;
   logic [7:0] wdata = 8'h00, rdata, e_v, lcr, dat;
   logic vprev = 1'b1, valid_n, sel, xdis, irq, tick_n, rxc, tx, rx;
   logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n;
   logic [1:0] uo_n;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h97ba;
   int err_total = 0, n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   always #21 ref_clk = ~ref_clk;
   acex_top i_dut (.clk_sys(clk_sys), .reset(reset),
      .master_reset(master_reset), .select_latch_strobe_n(latch_n),
      .reg_sel(reg_sel), .chip_select_inputs(cs_in),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
      .host_wdata(wdata), .host_rdata(rdata), .rdata_valid_n(valid_n),
      .selected_indicator(sel), .xcvr_disable(xdis), .irq_out(irq),
      .baud_ref_clock(ref_clk), .baud_tick_out_n(tick_n),
      .rx_clock16(rxc), .serial_tx(tx), .serial_rx(rx),
      .clear_to_send_n(cts_n), .set_ready_n(dsr_n), .ring_detect_n(ri_n),
      .carrier_detect_n(dcd_n), .terminal_ready_n(dtr_n),
      .request_to_send_n(rts_n), .user_outputs_n(uo_n));
   acex_modem i_modem (.serial_tx(tx), .echo_on(echo_on),
      .baud_tick_out_n(tick_n), .serial_rx(rx), .rx_clock16(rxc),
      .clear_to_send_n(cts_n), .set_ready_n(dsr_n), .ring_detect_n(ri_n),
      .carrier_detect_n(dcd_n));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task final_report;
      `CHK("reads left", 0, exp_q.size())
      if (err_total == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task acc(input logic w, input logic [2:0] a, input logic [7:0] d,
            input logic [2:0] cs);
      @(negedge clk_sys);
      latch_n = 1'b0; reg_sel = a; cs_in = cs; wdata = d;
      @(negedge clk_sys);
      latch_n = 1'b1; rd_n = w; wr_n = !w;
      repeat (3) @(negedge clk_sys);
      rd_n = 1'b1; wr_n = 1'b1;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00, 3'b011);
   endtask
   // Each fresh fall of the valid line consumes the oldest expectation.
   always @(posedge clk_sys) begin
      if (!valid_n && vprev) begin
         e_v = exp_q.size() ? exp_q.pop_front() : 8'hxx;
         `CHK("read data", e_v, rdata)
      end
      vprev <= valid_n;
   end
   initial begin
      #200_000;
      err_total++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys) reset = 1'b0;
      rd(3'h6, 8'hBB);
      rd(3'h6, 8'hB0);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         acc(1'b1, 3'h7, seed[7:0], 3'b011);
         rd(3'h7, seed[7:0]);
      end
      acc(1'b1, 3'h7, 8'h5A, 3'b111);
      rd(3'h7, seed[7:0]);
      acc(1'b1, 3'h3, 8'h80, 3'b011);
      acc(1'b1, 3'h0, 8'h01, 3'b011);
      acc(1'b1, 3'h1, 8'h00, 3'b011);
      // Every length once; stop, parity and data come from the generator.
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         lp = !i[0];
         lcr = {3'b000, seed[10:8], i[1:0]};
         dat = seed[7:0] & (8'hFF >> (3 - i));
         if (!lp) echo_on = 1'b1;
         acc(1'b1, 3'h4, {3'b000, lp, 4'hF}, 3'b011);
         echo_on = !lp;
         `CHK("modem outs", {4{lp}}, {dtr_n, rts_n, uo_n})
         acc(1'b1, 3'h3, lcr, 3'b011);
         acc(1'b1, 3'h1, 8'h01, 3'b011);
         acc(1'b1, 3'h0, dat, 3'b011);
         repeat (30) @(negedge clk_sys);
         if (lp) `CHK("tx idle in loop", 1'b1, tx)
         repeat (1000) @(negedge clk_sys);
         `CHK("irq raised", 1'b1, irq)
         rd(3'h5, 8'h61);
         rd(3'h0, dat);
         `CHK("irq cleared", 1'b0, irq)
      end
      acc(1'b1, 3'h3, 8'h40, 3'b011);
      repeat (600) @(negedge clk_sys);
      rd(3'h5, 8'h79);
      rd(3'h0, 8'h00);
      master_reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      master_reset = 1'b0;
      `CHK("idle outs", 5'h1F, {dtr_n, rts_n, uo_n, tx})
      rd(3'h7, 8'h00);
      final_report();
   end
endmodule // testbench
